// ---- design/cmp_ctrl_pkg.sv ----
// package: register map, field positions and reset values of the comparator control
package cmp_ctrl_pkg;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] MASK_OFFSET   = 12'h008;
  localparam int STOP_IDLE_BIT = 15;
  localparam int EVT2_BIT      = 13;
  localparam int EVT1_BIT      = 12;
  localparam int ON2_BIT       = 11;
  localparam int ON1_BIT       = 10;
  localparam int PAD2_BIT      = 9;
  localparam int PAD1_BIT      = 8;
  localparam int RES2_BIT      = 7;
  localparam int RES1_BIT      = 6;
  localparam int INV2_BIT      = 5;
  localparam int INV1_BIT      = 4;
  localparam int SEL_LSB       = 0;
  localparam int SEL_W         = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0]  MASK_RESET = 2'h0;
  localparam int SYNC_STAGES   = 3;
endpackage : cmp_ctrl_pkg

// ---- design/cmp_sync.sv ----
// three-flop synchroniser with agreement check for a raw comparator output
`timescale 1ns/100ps
module cmp_sync
  import cmp_ctrl_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw_in,
  output logic      level_out
);
  logic [SYNC_STAGES-1:0] stage_r;

  // the agreement check reads stages two and three, so fewer is unusable
  if (SYNC_STAGES < 3)
  begin : g_bad_stages
    $error("cmp_sync needs at least three stages");
  end

  // shift chain; the first flop feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_r <= '0;
    else
      stage_r <= {stage_r[SYNC_STAGES-2:0], raw_in};
  end

  // accept a new level only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_out <= 1'b0;
    else if (stage_r[1] == stage_r[2])
      level_out <= stage_r[2];
  end
endmodule : cmp_sync

// ---- design/dual_comparator_control.sv ----
// dual analog comparator control, status and interrupt logic on apb
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
// Contract
// - comparator 2 change sets its event flag
// - comparator 1 change sets its event flag
// - cmp2_on bit switches comparator 2
// - cmp1_on bit switches comparator 1
// - cmp2_pad_drive gates result onto pad
// - cmp1_pad_drive gates result onto pad
// - cmp2_result follows inputs, invert flips it
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               cmp1_raw,
  input  wire logic               cmp2_raw,
  input  wire logic               idle_mode,
  output logic                    cmp1_on,
  output logic                    cmp2_on,
  output logic      [SEL_W-1:0]   input_select,
  output logic                    cmp1_pad_out,
  output logic                    cmp1_pad_oe,
  output logic                    cmp2_pad_out,
  output logic                    cmp2_pad_oe,
  output logic                    cmp_irq
);
  import cmp_ctrl_pkg::*;

  logic        stop_when_idle_r;
  logic        cmp1_invert_r;
  logic        cmp2_invert_r;
  logic        cmp1_pad_drive_r;
  logic        cmp2_pad_drive_r;
  logic [1:0]  evt_r;
  logic [1:0]  mask_r;
  logic        cmp1_level;
  logic        cmp2_level;
  logic        cmp1_result;
  logic        cmp2_result;
  logic        cmp1_prev_r;
  logic        cmp2_prev_r;
  logic [1:0]  change;
  logic        wr_en;
  logic        rd_en;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic        addr_ok;
  logic [15:0] ctrl_rd;
  logic [31:0] rd_nxt;

  // one address compare, shared by decode and write strobes; the read mux cases on paddr itself
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  // the select field must sit below the invert bits, else fields overlap
  if (SEL_LSB + SEL_W > INV1_BIT)
  begin : g_bad_layout
    $error("select field overlaps the invert bits");
  end
  // every control field has to fit the 16-bit readback image
  if (STOP_IDLE_BIT > 15)
  begin : g_bad_stop
    $error("control fields must fit the 16-bit image");
  end

  // raw analog outputs are asynchronous to pclk
  cmp_sync u_sync1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .raw_in    (cmp1_raw),
    .level_out (cmp1_level)
  );
  cmp_sync u_sync2 (
    .pclk      (pclk),
    .presetn   (presetn),
    .raw_in    (cmp2_raw),
    .level_out (cmp2_level)
  );

  assign cmp2_result = cmp2_on & (cmp2_level ^ cmp2_invert_r);
  // comparator 1 uses same polarity scheme
  assign cmp1_result = cmp1_on & (cmp1_level ^ cmp1_invert_r);

  // apb decode; single access phase, zero wait states
  assign addr_ok = addr_hit(paddr, CTRL_OFFSET)
                || addr_hit(paddr, STATUS_OFFSET)
                || addr_hit(paddr, MASK_OFFSET);
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & ~penable & ~pwrite;

  // write strobes, one per register, only in the access phase
  assign wr_ctrl = wr_en & addr_hit(paddr, CTRL_OFFSET);
  assign wr_stat = wr_en & addr_hit(paddr, STATUS_OFFSET);
  assign wr_mask = wr_en & addr_hit(paddr, MASK_OFFSET);

  // previous result, used to spot a change of state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp1_prev_r <= 1'b0;
      cmp2_prev_r <= 1'b0;
    end
    else
    begin
      cmp1_prev_r <= cmp1_result;
      cmp2_prev_r <= cmp2_result;
    end
  end

  assign change[1] = cmp2_result ^ cmp2_prev_r;
  assign change[0] = cmp1_result ^ cmp1_prev_r;

  // mode fields: stop-in-idle, polarity and input select
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_when_idle_r <= CTRL_RESET[STOP_IDLE_BIT];
      cmp2_invert_r    <= CTRL_RESET[INV2_BIT];
      cmp1_invert_r    <= CTRL_RESET[INV1_BIT];
      input_select     <= CTRL_RESET[SEL_LSB +: SEL_W];
    end
    else if (wr_ctrl)
    begin
      stop_when_idle_r <= pwdata[STOP_IDLE_BIT];
      cmp2_invert_r    <= pwdata[INV2_BIT];
      cmp1_invert_r    <= pwdata[INV1_BIT];
      input_select     <= pwdata[SEL_LSB +: SEL_W];
    end
  end

  // comparator enables; the analog cores follow these directly
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp2_on <= CTRL_RESET[ON2_BIT];
      cmp1_on <= CTRL_RESET[ON1_BIT];
    end
    else if (wr_ctrl)
    begin
      cmp2_on <= pwdata[ON2_BIT];
      cmp1_on <= pwdata[ON1_BIT];
    end
  end

  // pad drive requests; they reach the pins one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp2_pad_drive_r <= CTRL_RESET[PAD2_BIT];
      cmp1_pad_drive_r <= CTRL_RESET[PAD1_BIT];
    end
    else if (wr_ctrl)
    begin
      cmp2_pad_drive_r <= pwdata[PAD2_BIT];
      cmp1_pad_drive_r <= pwdata[PAD1_BIT];
    end
  end

  // sticky events; a change in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_r <= 2'h0;
    // zero written to control clears flag
    else if (wr_ctrl)
      evt_r <= change | (evt_r & {pwdata[EVT2_BIT], pwdata[EVT1_BIT]});
    // write one clears via the status alias
    else if (wr_stat)
      evt_r <= change | (evt_r & ~pwdata[1:0]);
    else
      evt_r <= evt_r | change;
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= MASK_RESET;
    else if (wr_mask)
      mask_r <= pwdata[1:0];
  end

  // comparator 1 pad; registered so the pin never glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp1_pad_out <= 1'b0;
      cmp1_pad_oe  <= 1'b0;
    end
    else
    begin
      // pad only meaningful once remappable_pin routed
      cmp1_pad_oe  <= cmp1_pad_drive_r;
      cmp1_pad_out <= cmp1_pad_drive_r & cmp1_result;
    end
  end

  // comparator 2 pad; out held low while not driven
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp2_pad_out <= 1'b0;
      cmp2_pad_oe  <= 1'b0;
    end
    else
    begin
      cmp2_pad_oe  <= cmp2_pad_drive_r;
      cmp2_pad_out <= cmp2_pad_drive_r & cmp2_result;
    end
  end

  // level interrupt; comparators stay on while idle blocks it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_irq <= 1'b0;
    else
      cmp_irq <= |(evt_r & mask_r) & ~(stop_when_idle_r & idle_mode);
  end

  // readback image of the control register
  always_comb
  begin
    ctrl_rd                          = 16'h0000;
    ctrl_rd[STOP_IDLE_BIT]           = stop_when_idle_r;
    ctrl_rd[EVT2_BIT]                = evt_r[1];
    ctrl_rd[EVT1_BIT]                = evt_r[0];
    ctrl_rd[ON2_BIT]                 = cmp2_on;
    ctrl_rd[ON1_BIT]                 = cmp1_on;
    ctrl_rd[PAD2_BIT]                = cmp2_pad_drive_r;
    ctrl_rd[PAD1_BIT]                = cmp1_pad_drive_r;
    ctrl_rd[RES2_BIT]                = cmp2_result;
    ctrl_rd[RES1_BIT]                = cmp1_result;
    ctrl_rd[INV2_BIT]                = cmp2_invert_r;
    ctrl_rd[INV1_BIT]                = cmp1_invert_r;
    ctrl_rd[SEL_LSB +: SEL_W]        = input_select;
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFFSET:   rd_nxt = {16'h0000, ctrl_rd};
      STATUS_OFFSET: rd_nxt = {30'h0, evt_r};
      MASK_OFFSET:   rd_nxt = {30'h0, mask_r};
      default:       rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data captured in setup so it is stable for the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= rd_nxt;
  end

  // always ready; error flagged for unmapped addresses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= 1'b1;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end
endmodule : dual_comparator_control

// ---- verif/cmp_ctrl_properties.sv ----
// checker: apb, enable and pad assertions for the comparator control
`timescale 1ns/100ps
module cmp_ctrl_properties
  import cmp_ctrl_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmp1_on,
  input wire logic        cmp2_on,
  input wire logic        cmp1_pad_out,
  input wire logic        cmp1_pad_oe,
  input wire logic        cmp2_pad_out,
  input wire logic        cmp2_pad_oe,
  input wire logic        cmp_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ctrl;
  logic unmap;
  // decoded bus events
  assign wr_ctrl = psel && penable && pwrite && paddr == CTRL_OFFSET;
  assign unmap = paddr != CTRL_OFFSET && paddr != STATUS_OFFSET &&
                 paddr != MASK_OFFSET;
  a_ready_always: assert property (pready) else $error("pready low");
  a_pad1_gated:
    assert property (!cmp1_pad_oe |-> !cmp1_pad_out) else $error("pad1");
  a_pad2_gated:
    assert property (!cmp2_pad_oe |-> !cmp2_pad_out) else $error("pad2");
  a_on1_write:
    assert property (wr_ctrl |=> cmp1_on == $past(pwdata[ON1_BIT]))
    else $error("on1");
  a_on2_write:
    assert property (wr_ctrl |=> cmp2_on == $past(pwdata[ON2_BIT]))
    else $error("on2");
  a_oe1_write:
    assert property (wr_ctrl |=> ##1
      cmp1_pad_oe == $past(pwdata[PAD1_BIT], 2))
    else $error("oe1");
  a_oe2_write:
    assert property (wr_ctrl |=> ##1
      cmp2_pad_oe == $past(pwdata[PAD2_BIT], 2))
    else $error("oe2");
  a_ctrl_hold:
    assert property (!wr_ctrl ##1 !wr_ctrl |=>
      $stable({cmp1_on, cmp2_on, cmp1_pad_oe, cmp2_pad_oe}))
    else $error("ctrl moved");
  a_err_unmapped:
    assert property (psel && !penable && unmap |=> pslverr) else $error("err");
  c_ctrl: cover property (wr_ctrl);
  c_irq: cover property ($rose(cmp_irq));
  c_unmap: cover property (psel && unmap);
endmodule : cmp_ctrl_properties

bind dual_comparator_control cmp_ctrl_properties cmp_ctrl_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .cmp1_on(cmp1_on), .cmp2_on(cmp2_on),
  .cmp1_pad_out(cmp1_pad_out), .cmp1_pad_oe(cmp1_pad_oe),
  .cmp2_pad_out(cmp2_pad_out), .cmp2_pad_oe(cmp2_pad_oe), .cmp_irq(cmp_irq));

// ---- verif/test_dual_comparator_control.sv ----
// testbench: apb register, event, pad and interrupt checks
`timescale 1ns/100ps
module test_dual_comparator_control;
  import cmp_ctrl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cmp1_raw, cmp2_raw, idle_mode, cmp_irq, rerr;
  logic        cmp1_on, cmp2_on, p1_out, p1_oe, p2_out, p2_oe;
  logic [11:0] paddr;
  logic [3:0]  sel;
  logic [31:0] pwdata, prdata, rdat;
  int          n_errors, cmp_count;
  dual_comparator_control dual_comparator_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp1_raw(cmp1_raw),
    .cmp2_raw(cmp2_raw), .idle_mode(idle_mode), .cmp1_on(cmp1_on),
    .cmp2_on(cmp2_on), .input_select(sel), .cmp1_pad_out(p1_out),
    .cmp1_pad_oe(p1_oe), .cmp2_pad_out(p2_out), .cmp2_pad_oe(p2_oe),
    .cmp_irq(cmp_irq));
  // free-running bus clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // one apb transfer; waits an edge first so psel never toggles twice
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
    begin
      n_errors++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, idle_mode, cmp1_raw, cmp2_raw} = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFFSET);
    chk("ctrl rst", rdat, {16'h0, CTRL_RESET});
    rd(MASK_OFFSET);
    chk("mask rst", rdat, {30'h0, MASK_RESET});
    cmp1_raw <= 1'b1;
    // pads treated as routed to a remappable_pin before enabling
    xfer(1'b1, CTRL_OFFSET, 32'h0F00);
    repeat (8) @(posedge pclk);
    rd(CTRL_OFFSET);
    chk("ctrl on", rdat, 32'h1F40);
    chk("pads", {p2_oe, p2_out, p1_oe, p1_out}, 4'hB);
    // writing zero to event 1 clears it while inversion raises event 2
    xfer(1'b1, CTRL_OFFSET, 32'h0F20);
    repeat (8) @(posedge pclk);
    rd(CTRL_OFFSET);
    chk("invert", rdat, 32'h2FE0);
    rd(STATUS_OFFSET);
    chk("status", rdat, 32'h2);
    xfer(1'b1, MASK_OFFSET, 32'h1);
    repeat (2) @(posedge pclk);
    chk("masked", cmp_irq, 1'b0);
    xfer(1'b1, MASK_OFFSET, 32'h3);
    repeat (2) @(posedge pclk);
    chk("irq", cmp_irq, 1'b1);
    xfer(1'b1, CTRL_OFFSET, 32'hAF20);
    idle_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("idle", {cmp_irq, cmp1_on, cmp2_on}, 3'h3);
    idle_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("wake", cmp_irq, 1'b1);
    xfer(1'b1, STATUS_OFFSET, 32'h2);
    repeat (2) @(posedge pclk);
    chk("clear", cmp_irq, 1'b0);
    {cmp1_raw, cmp2_raw} <= 2'b01;
    repeat (8) @(posedge pclk);
    rd(STATUS_OFFSET);
    chk("raw evt", rdat, 32'h3);
    rd(CTRL_OFFSET);
    chk("ctrl raw", rdat, 32'hBF20);
    xfer(1'b1, CTRL_OFFSET, 32'h0C05);
    repeat (2) @(posedge pclk);
    chk("pads off", {p2_oe, p2_out, p1_oe, p1_out}, 4'h0);
    chk("select", sel, 4'h5);
    xfer(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk("unmapped wr err", rerr, 1'b1);
    rd(12'h00C);
    chk("unmapped rd", rdat, 32'h0);
    chk("unmapped rd err", rerr, 1'b1);
    stop_test();
  end
  // hang guard
  initial
  begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule : test_dual_comparator_control
